// file: design/ssio_pkg.sv
// Purpose: Shared constants and types of the speed starter I/O control block.
// Assumes: 250 MHz aclk, AXI4-Lite register access with 32-bit data.
// Notes: Every offset, field position and timing count lives here.
package ssio_pkg;

    localparam int AXI_AW = 8;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_FAULT_CODE = 8'h08;
    localparam logic [7:0] REG_FREQ = 8'h0C;
    localparam logic [7:0] REG_CONFIG = 8'h10;

    localparam int CTRL_ACK_BIT = 0;

    localparam int STAT_ROT_CW_BIT = 0;
    localparam int STAT_ROT_CCW_BIT = 1;
    localparam int STAT_SPEED_LSB = 2;
    localparam int STAT_SENSOR_A_BIT = 4;
    localparam int STAT_SENSOR_B_BIT = 5;
    localparam int STAT_FLT_ACTIVE_BIT = 6;
    localparam int STAT_FLT_LATCHED_BIT = 7;
    localparam int STAT_PROC_A_BIT = 8;
    localparam int STAT_PROC_B_BIT = 9;
    localparam int STAT_GRP_RAW_BIT = 10;

    localparam int CFG_MASK_THERM_BIT = 0;
    localparam int CFG_SPARE_BIT = 1;
    localparam int CFG_INVERT_BIT = 2;
    localparam int CFG_VALID_BIT = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [5:0] FREQ_FF1_HZ = 6'h1E;
    localparam logic [5:0] FREQ_FF2_HZ = 6'h28;
    localparam logic [5:0] FREQ_FF3_HZ = 6'h32;
    localparam logic [5:0] FREQ_POT_MAX_HZ = 6'h32;

    localparam logic [7:0] RST_FAULT_CODE = 8'h00;
    localparam logic [1:0] DIP_SETTLE_CNT = 2'h3;

    localparam int CLK_MHZ = 250;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * CLK_MHZ * 1000;

    localparam int SYNC_W = 29;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } ssio_axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ssio_axi_rsp_type;

    typedef struct packed {
        logic cmd_dir_cw_bit;
        logic cmd_dir_ccw_bit;
        logic cmd_speed_sel_lo;
        logic cmd_speed_sel_hi;
    } ssio_cmd_type;

    typedef struct packed {
        logic drive_fault;
        logic thermistor_fault;
        logic cable_fault;
        logic sensor_ovl_a;
        logic sensor_ovl_b;
    } ssio_fault_src_type;

    typedef enum logic [2:0] {
        FLT_IDLE = 3'h1,
        FLT_ACTIVE = 3'h2,
        FLT_LATCHED = 3'h4
    } ssio_flt_type;

    typedef struct packed {
        ssio_axi_rsp_type rsp;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [1:0] init_cnt;
        logic dip_valid;
        logic dip_mask_therm;
        logic dip_spare;
        logic dip_invert;
        ssio_flt_type flt;
        logic [25:0] flash_cnt;
        logic flash_on;
        logic key_prev;
        logic [7:0] fault_code;
        logic rot_cw;
        logic rot_ccw;
        logic [1:0] speed_code;
        logic [5:0] freq_hz;
        logic stat_a;
        logic stat_b;
        logic proc_a;
        logic proc_b;
        logic led_red;
        logic grp_raw;
    } ssio_state_type;

endpackage

// file: design/ssio_sync.sv
// Purpose: Two-stage synchroniser for a vector of asynchronous inputs.
// Assumes: Each bit is independent; multi-bit words must be quasi-static.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
module ssio_sync #(
    parameter int W = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// file: design/ssio_top.sv
// Purpose: Command decode, sensor status and group fault indication of a
//          networked motor speed starter, with an AXI4-Lite register view.
// Assumes: All field inputs are asynchronous and pass two flip-flops first;
//          the fault code and potentiometer words are stable for many cycles.
// Notes: Direction outputs and the fault lamp stay off until the configuration switches are captured.
//
// Added by the designer: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module ssio_top #(
    parameter int unsigned FLASH_HALF_CYC = ssio_pkg::FLASH_HALF_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input ssio_pkg::ssio_axi_req_type axi_req,
    output ssio_pkg::ssio_axi_rsp_type axi_rsp,
    input ssio_pkg::ssio_cmd_type cmd,
    input wire logic sensor_chan_a,
    input wire logic sensor_chan_b,
    input ssio_pkg::ssio_fault_src_type fault_src,
    input wire logic [7:0] drive_fault_code,
    input wire logic key_off_reset,
    input wire logic [5:0] pot_setpoint_freq,
    input wire logic [2:0] dip_switch,
    output logic rotate_clockwise,
    output logic rotate_anticlockwise,
    output logic [1:0] speed_code,
    output logic [5:0] out_freq_hz,
    output logic stat_sensor_a,
    output logic stat_sensor_b,
    output logic sensor_proc_a,
    output logic sensor_proc_b,
    output logic fault_led_red
);
    ssio_pkg::ssio_state_type st_q;
    ssio_pkg::ssio_state_type st_d;

    logic [ssio_pkg::SYNC_W-1:0] raw_in;
    logic [ssio_pkg::SYNC_W-1:0] sync_in;

    ssio_pkg::ssio_cmd_type s_cmd;
    ssio_pkg::ssio_fault_src_type s_flt;
    logic s_sensor_a;
    logic s_sensor_b;
    logic s_key;
    logic [2:0] s_dip;
    logic [7:0] s_code;
    logic [5:0] s_pot;

    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic sw_ack;
    logic key_rise;
    logic reset_cmd;
    logic grp_fault;
    logic flt_direct;
    logic flt_motor;
    logic [25:0] flash_last;

    // Packing order must match the unpacking after the synchroniser
    assign raw_in = {cmd, sensor_chan_a, sensor_chan_b,
                     fault_src, key_off_reset,
                     dip_switch,
                     drive_fault_code, pot_setpoint_freq};

    // One synchroniser for every field pin; the two words must be quasi-static
    ssio_sync #(
        .W(ssio_pkg::SYNC_W)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(raw_in),
        .sync_out(sync_in)
    );

    assign {s_cmd, s_sensor_a, s_sensor_b,
            s_flt, s_key,
            s_dip,
            s_code, s_pot} = sync_in;

    assign flash_last = 26'(FLASH_HALF_CYC - 1);

    // Register read view; unmapped offsets answer SLVERR with zero data
    // Fields come from the same registers that drive the outputs
    function automatic logic [33:0] read_word(input logic [7:0] addr,
                                              input ssio_pkg::ssio_state_type st);
        logic [31:0] d;
        logic [1:0] r;
        d = 32'h0000_0000;
        r = ssio_pkg::RESP_OKAY;
        case (addr)
            ssio_pkg::REG_CTRL: begin
                d = 32'h0000_0000;
            end
            ssio_pkg::REG_STATUS: begin
                d[ssio_pkg::STAT_ROT_CW_BIT] = st.rot_cw;
                d[ssio_pkg::STAT_ROT_CCW_BIT] = st.rot_ccw;
                d[ssio_pkg::STAT_SPEED_LSB +: 2] = st.speed_code;
                d[ssio_pkg::STAT_SENSOR_A_BIT] = st.stat_a;
                d[ssio_pkg::STAT_SENSOR_B_BIT] = st.stat_b;
                d[ssio_pkg::STAT_FLT_ACTIVE_BIT] = (st.flt == ssio_pkg::FLT_ACTIVE);
                d[ssio_pkg::STAT_FLT_LATCHED_BIT] = (st.flt == ssio_pkg::FLT_LATCHED);
                d[ssio_pkg::STAT_PROC_A_BIT] = st.proc_a;
                d[ssio_pkg::STAT_PROC_B_BIT] = st.proc_b;
                d[ssio_pkg::STAT_GRP_RAW_BIT] = st.grp_raw;
            end
            ssio_pkg::REG_FAULT_CODE: begin
                d[7:0] = st.fault_code;
            end
            ssio_pkg::REG_FREQ: begin
                d[5:0] = st.freq_hz;
            end
            ssio_pkg::REG_CONFIG: begin
                d[ssio_pkg::CFG_MASK_THERM_BIT] = st.dip_mask_therm;
                d[ssio_pkg::CFG_SPARE_BIT] = st.dip_spare;
                d[ssio_pkg::CFG_INVERT_BIT] = st.dip_invert;
                d[ssio_pkg::CFG_VALID_BIT] = st.dip_valid;
            end
            default: begin
                r = ssio_pkg::RESP_SLVERR;
            end
        endcase
        return {r, d};
    endfunction

    function automatic logic addr_mapped(input logic [7:0] addr);
        logic m;
        m = 1'b0;
        case (addr)
            ssio_pkg::REG_CTRL,
            ssio_pkg::REG_STATUS,
            ssio_pkg::REG_FAULT_CODE,
            ssio_pkg::REG_FREQ,
            ssio_pkg::REG_CONFIG: begin
                m = 1'b1;
            end
            default: begin
                m = 1'b0;
            end
        endcase
        return m;
    endfunction

    always_comb begin
        st_d = st_q;
        sw_ack = 1'b0;

        // Write channel: address and data are held until both have arrived
        aw_fire = axi_req.awvalid && st_q.rsp.awready;
        w_fire = axi_req.wvalid && st_q.rsp.wready;
        if (aw_fire) begin
            st_d.aw_hold = 1'b1;
            st_d.aw_addr = axi_req.awaddr;
        end
        if (w_fire) begin
            st_d.w_hold = 1'b1;
            st_d.w_data = axi_req.wdata;
            st_d.w_strb = axi_req.wstrb;
        end
        if (st_q.rsp.bvalid && axi_req.bready) begin
            st_d.rsp.bvalid = 1'b0;
        end
        if (st_d.aw_hold && st_d.w_hold && !st_q.rsp.bvalid) begin
            // Only the control word has writable bits; other mapped words ignore data
            if (addr_mapped(st_d.aw_addr)) begin
                st_d.rsp.bresp = ssio_pkg::RESP_OKAY;
            end else begin
                st_d.rsp.bresp = ssio_pkg::RESP_SLVERR;
            end
            // A software acknowledge has the same effect as a key press
            if (st_d.aw_addr == ssio_pkg::REG_CTRL && st_d.w_strb[0] &&
                st_d.w_data[ssio_pkg::CTRL_ACK_BIT]) begin
                sw_ack = 1'b1;
            end
            st_d.rsp.bvalid = 1'b1;
            st_d.aw_hold = 1'b0;
            st_d.w_hold = 1'b0;
        end
        st_d.rsp.awready = !st_d.aw_hold && !st_d.rsp.bvalid;
        st_d.rsp.wready = !st_d.w_hold && !st_d.rsp.bvalid;

        // Read channel: one outstanding read, answered the cycle after address
        ar_fire = axi_req.arvalid && st_q.rsp.arready;
        if (st_q.rsp.rvalid && axi_req.rready) begin
            st_d.rsp.rvalid = 1'b0;
        end
        if (ar_fire) begin
            {st_d.rsp.rresp, st_d.rsp.rdata} = read_word(axi_req.araddr, st_q);
            st_d.rsp.rvalid = 1'b1;
        end
        st_d.rsp.arready = !st_d.rsp.rvalid;

        // Switches are sampled once the synchroniser has filled, then frozen
        if (!st_q.dip_valid) begin
            if (st_q.init_cnt == ssio_pkg::DIP_SETTLE_CNT) begin
                st_d.dip_valid = 1'b1;
                st_d.dip_mask_therm = s_dip[0];
                st_d.dip_spare = s_dip[1];
                st_d.dip_invert = s_dip[2];
            end else begin
                st_d.init_cnt = st_q.init_cnt + 2'h1;
            end
        end

        // Reported status keeps the pin level; inversion applies inside only
        st_d.stat_a = s_sensor_a;
        st_d.stat_b = s_sensor_b;
        st_d.proc_a = s_sensor_a ^ st_q.dip_invert;
        st_d.proc_b = s_sensor_b ^ st_q.dip_invert;

        // Nothing may run before the switches are known, to avoid a stray start
        st_d.rot_cw = st_q.dip_valid &&
                      s_cmd.cmd_dir_cw_bit && !s_cmd.cmd_dir_ccw_bit;
        st_d.rot_ccw = st_q.dip_valid &&
                       !s_cmd.cmd_dir_cw_bit && s_cmd.cmd_dir_ccw_bit;

        // Speed follows the command even while no direction is enabled
        st_d.speed_code = {s_cmd.cmd_speed_sel_hi, s_cmd.cmd_speed_sel_lo};
        case ({s_cmd.cmd_speed_sel_hi, s_cmd.cmd_speed_sel_lo})
            2'h1: begin
                st_d.freq_hz = ssio_pkg::FREQ_FF1_HZ;
            end
            2'h2: begin
                st_d.freq_hz = ssio_pkg::FREQ_FF2_HZ;
            end
            2'h3: begin
                st_d.freq_hz = ssio_pkg::FREQ_FF3_HZ;
            end
            default: begin
                // Potentiometer span ends at 50 Hz; larger readings are clamped
                if (s_pot > ssio_pkg::FREQ_POT_MAX_HZ) begin
                    st_d.freq_hz = ssio_pkg::FREQ_POT_MAX_HZ;
                end else begin
                    st_d.freq_hz = s_pot;
                end
            end
        endcase

        // Thermal and cable share one mask switch. No source counts before the
        // switches are known, else a masked fault at power up would latch
        flt_direct = s_flt.drive_fault || s_flt.sensor_ovl_a || s_flt.sensor_ovl_b;
        flt_motor = s_flt.thermistor_fault || s_flt.cable_fault;
        if (st_q.dip_mask_therm) begin
            flt_motor = 1'b0;
        end
        grp_fault = st_q.dip_valid && (flt_direct || flt_motor);
        st_d.grp_raw = grp_fault;

        if (s_flt.drive_fault) begin
            st_d.fault_code = s_code;
        end

        // Only a fresh press counts; a key left in the reset position
        // must not clear a fault that appears later
        key_rise = s_key && !st_q.key_prev;
        st_d.key_prev = s_key;
        reset_cmd = key_rise || sw_ack;

        // A fault present in the same cycle as a reset keeps the lamp on
        case (st_q.flt)
            ssio_pkg::FLT_IDLE: begin
                if (grp_fault) begin
                    st_d.flt = ssio_pkg::FLT_ACTIVE;
                end
            end
            ssio_pkg::FLT_ACTIVE: begin
                // Reset is ignored here, so a hot motor cannot be acknowledged
                if (!grp_fault) begin
                    st_d.flt = ssio_pkg::FLT_LATCHED;
                end
            end
            ssio_pkg::FLT_LATCHED: begin
                if (grp_fault) begin
                    st_d.flt = ssio_pkg::FLT_ACTIVE;
                end else if (reset_cmd) begin
                    st_d.flt = ssio_pkg::FLT_IDLE;
                    st_d.fault_code = ssio_pkg::RST_FAULT_CODE;
                end
            end
            default: begin
                st_d.flt = ssio_pkg::FLT_IDLE;
            end
        endcase

        // Counter restarts on each entry, so every flash sequence starts lit
        if (st_d.flt == ssio_pkg::FLT_LATCHED) begin
            if (st_q.flash_cnt >= flash_last) begin
                st_d.flash_cnt = 26'h000_0000;
                st_d.flash_on = !st_q.flash_on;
            end else begin
                st_d.flash_cnt = st_q.flash_cnt + 26'h000_0001;
            end
        end else begin
            st_d.flash_cnt = 26'h000_0000;
            st_d.flash_on = 1'b1;
        end

        case (st_d.flt)
            ssio_pkg::FLT_ACTIVE: begin
                st_d.led_red = 1'b1;
            end
            ssio_pkg::FLT_LATCHED: begin
                st_d.led_red = st_d.flash_on;
            end
            default: begin
                st_d.led_red = 1'b0;
            end
        endcase
    end

    // The idle state code is not all zero, so reset sets it apart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
            st_q.flt <= ssio_pkg::FLT_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign axi_rsp = st_q.rsp;
    assign rotate_clockwise = st_q.rot_cw;
    assign rotate_anticlockwise = st_q.rot_ccw;
    assign speed_code = st_q.speed_code;
    assign out_freq_hz = st_q.freq_hz;
    assign stat_sensor_a = st_q.stat_a;
    assign stat_sensor_b = st_q.stat_b;
    assign sensor_proc_a = st_q.proc_a;
    assign sensor_proc_b = st_q.proc_b;
    assign fault_led_red = st_q.led_red;
endmodule

// file: test/speed_starter_io_control_test.sv
// Purpose: Self-checking bench for the speed starter I/O block.
// Assumes: Short flash period; fixed seed for repeatable random values.
// Notes: Second reset stands in for a power cycle with new switch settings.
`timescale 1ns/1ps
module speed_starter_io_control_test;
    localparam int unsigned FH = 8;
    logic aclk, aresetn, sens_a, sens_b, key, slow, masked;
    logic rot_cw, rot_ccw, st_a, st_b, pr_a, pr_b, led;
    logic [1:0] spd, in_img;
    logic [2:0] dip;
    logic [3:0] out_img;
    logic [5:0] pot, frq;
    logic [7:0] fcode;
    ssio_pkg::ssio_axi_req_type req;
    ssio_pkg::ssio_axi_rsp_type rsp;
    ssio_pkg::ssio_cmd_type cmd;
    ssio_pkg::ssio_fault_src_type fsrc;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    ssio_top #(.FLASH_HALF_CYC(FH)) dut_u (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
        .axi_rsp(rsp), .cmd(cmd), .sensor_chan_a(sens_a), .sensor_chan_b(sens_b),
        .fault_src(fsrc), .drive_fault_code(fcode), .key_off_reset(key),
        .pot_setpoint_freq(pot), .dip_switch(dip), .rotate_clockwise(rot_cw),
        .rotate_anticlockwise(rot_ccw), .speed_code(spd), .out_freq_hz(frq),
        .stat_sensor_a(st_a), .stat_sensor_b(st_b), .sensor_proc_a(pr_a),
        .sensor_proc_b(pr_b), .fault_led_red(led));
    ssio_asi_master master_u (.aclk(aclk), .slow(slow), .out_image(out_img),
        .stat_a(st_a), .stat_b(st_b), .cmd(cmd), .in_image(in_img));
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Ceiling is several times the expected run length
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask
    function automatic logic [5:0] exp_freq(input logic [1:0] sel, input logic [5:0] p);
        case (sel)
            2'h1: return ssio_pkg::FREQ_FF1_HZ;
            2'h2: return ssio_pkg::FREQ_FF2_HZ;
            2'h3: return ssio_pkg::FREQ_FF3_HZ;
            default: return (p > ssio_pkg::FREQ_POT_MAX_HZ) ? ssio_pkg::FREQ_POT_MAX_HZ : p;
        endcase
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        chk("bresp", rsp.bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        chk("rdata", rsp.rdata, ed);
        chk("rresp", rsp.rresp, er);
    endtask
    task automatic do_reset(input logic [2:0] d);
        @(posedge aclk);
        dip <= d;
        aresetn <= 1'b0;
        wt(5);
        aresetn <= 1'b1;
        wt(10);
    endtask
    task automatic sens_run(input logic inv);
        repeat (12) begin
            sens_a <= 1'($urandom);
            sens_b <= 1'($urandom);
            wt(14);
            chk("stat", {st_b, st_a}, {sens_b, sens_a});
            chk("proc", {pr_b, pr_a}, {sens_b ^ inv, sens_a ^ inv});
            chk("image", in_img, {sens_b, sens_a});
        end
    endtask
    task automatic flt_run(input int i, input logic off, input logic by_key);
        int tg;
        logic lp;
        fsrc <= ssio_pkg::ssio_fault_src_type'(5'h10 >> i);
        fcode <= 8'($urandom_range(255, 1));
        wt(6);
        chk("lit", led, !off);
        if (i == 0) rd(ssio_pkg::REG_FAULT_CODE, {24'h0, fcode}, ssio_pkg::RESP_OKAY);
        key <= 1'b1;
        wt(6);
        key <= 1'b0;
        chk("held", led, !off);
        fsrc <= '0;
        wt(6);
        tg = 0;
        lp = led;
        repeat (4 * FH) begin
            @(negedge aclk);
            if (led !== lp) tg++;
            lp = led;
        end
        chk("flash", tg, off ? 0 : 4);
        if (by_key) begin
            key <= 1'b1;
            wt(6);
            key <= 1'b0;
        end else begin
            wr(ssio_pkg::REG_CTRL, 32'h1, ssio_pkg::RESP_OKAY);
        end
        wt(6);
        chk("dark", led, 1'b0);
        if (i == 0) rd(ssio_pkg::REG_FAULT_CODE, 32'h0, ssio_pkg::RESP_OKAY);
    endtask
    initial begin
        void'($urandom(32'hA82008A9));
        req = '0;
        aresetn = 1'b0;
        {sens_a, sens_b, key, slow} = 4'h0;
        fsrc = '0;
        fcode = 8'h00;
        pot = 6'h00;
        dip = 3'h0;
        out_img = 4'h0;
        do_reset(3'h0);
        rd(ssio_pkg::REG_CONFIG, 32'h8, ssio_pkg::RESP_OKAY);
        rd(ssio_pkg::REG_STATUS, 32'h0, ssio_pkg::RESP_OKAY);
        rd(8'h14, 32'h0, ssio_pkg::RESP_SLVERR);
        wr(8'h14, 32'h1, ssio_pkg::RESP_SLVERR);
        wr(ssio_pkg::REG_STATUS, 32'hFFFF, ssio_pkg::RESP_OKAY);
        for (int i = 0; i < 16; i++) begin
            slow <= i[0];
            out_img <= i[3:0];
            pot <= 6'($urandom_range(63));
            wt(20);
            chk("dir", {rot_cw, rot_ccw}, {i[3] & ~i[2], i[2] & ~i[3]});
            chk("speed", spd, {i[0], i[1]});
            chk("freq", frq, exp_freq({i[0], i[1]}, pot));
        end
        sens_run(1'b0);
        for (int i = 0; i < 5; i++) flt_run(i, 1'b0, i[0]);
        do_reset(3'h5);
        rd(ssio_pkg::REG_CONFIG, 32'hD, ssio_pkg::RESP_OKAY);
        sens_run(1'b1);
        for (int i = 0; i < 5; i++) flt_run(i, i == 1 || i == 2, i[0]);
        dip <= 3'h0;
        wt(20);
        sens_run(1'b1);
        rd(ssio_pkg::REG_CONFIG, 32'hD, ssio_pkg::RESP_OKAY);
        stop_test();
    end
endmodule

// file: test/ssio_asi_master.sv
// Purpose: Behavioural fieldbus master writing four output bits, reading status.
// Assumes: One output image per bus cycle; slow mode stretches the cycle.
// Notes: Bits change only at a cycle boundary, as on the real bus.
`timescale 1ns/1ps
module ssio_asi_master (
    input wire logic aclk,
    input wire logic slow,
    input wire logic [3:0] out_image,
    input wire logic stat_a,
    input wire logic stat_b,
    output ssio_pkg::ssio_cmd_type cmd,
    output logic [1:0] in_image
);
    logic [2:0] tick = 3'h0;
    initial cmd = '0;
    initial in_image = 2'h0;
    always @(posedge aclk) begin
        tick <= (tick >= (slow ? 3'h5 : 3'h0)) ? 3'h0 : tick + 3'h1;
        if (tick == 3'h0) begin
            cmd <= ssio_pkg::ssio_cmd_type'(out_image);
            in_image <= {stat_b, stat_a};
        end
    end
endmodule

// file: test/ssio_props.sv
// Purpose: Concurrent checks on the ports of the speed starter I/O block.
// Assumes: Field inputs reach the outputs three edges after they change.
// Notes: Checks wait until 15 edges after reset, well past switch capture.
`timescale 1ns/1ps
module ssio_props #(
    parameter int unsigned FLASH_HALF_CYC = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input ssio_pkg::ssio_cmd_type cmd,
    input wire logic sensor_chan_a,
    input wire logic sensor_chan_b,
    input ssio_pkg::ssio_fault_src_type fault_src,
    input wire logic key_off_reset,
    input wire logic [5:0] pot_setpoint_freq,
    input wire logic rotate_clockwise,
    input wire logic rotate_anticlockwise,
    input wire logic [1:0] speed_code,
    input wire logic [5:0] out_freq_hz,
    input wire logic stat_sensor_a,
    input wire logic stat_sensor_b,
    input wire logic sensor_proc_a,
    input wire logic sensor_proc_b,
    input wire logic fault_led_red
);
    logic [3:0] alive_q;
    logic live;
    logic [1:0] dir_want;
    logic [1:0] sel_now;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alive_q <= 4'h0;
        end else if (alive_q != 4'hF) begin
            alive_q <= alive_q + 4'h1;
        end
    end
    assign live = (alive_q == 4'hF);
    assign dir_want = {cmd.cmd_dir_cw_bit & ~cmd.cmd_dir_ccw_bit,
                       cmd.cmd_dir_ccw_bit & ~cmd.cmd_dir_cw_bit};
    assign sel_now = {cmd.cmd_speed_sel_hi, cmd.cmd_speed_sel_lo};
    function automatic logic [5:0] freq_of(input logic [1:0] sel, input logic [5:0] p);
        case (sel)
            2'h1: return ssio_pkg::FREQ_FF1_HZ;
            2'h2: return ssio_pkg::FREQ_FF2_HZ;
            2'h3: return ssio_pkg::FREQ_FF3_HZ;
            default: return (p > ssio_pkg::FREQ_POT_MAX_HZ) ? ssio_pkg::FREQ_POT_MAX_HZ : p;
        endcase
    endfunction
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Any of the unmaskable sources held long enough to cross the synchroniser
    sequence src_held_s;
        (fault_src.drive_fault || fault_src.sensor_ovl_a || fault_src.sensor_ovl_b) [*4];
    endsequence
    sequence quiet_s;
        (fault_src == '0) [*6];
    endsequence
    sens_a_mirror_a: assert property (live |-> stat_sensor_a == $past(sensor_chan_a, 3))
        else $error("sensor a status differs from pin");
    sens_b_mirror_a: assert property (live |-> stat_sensor_b == $past(sensor_chan_b, 3))
        else $error("sensor b status differs from pin");
    proc_fixed_a: assert property (live |-> $stable({
        sensor_proc_a ^ stat_sensor_a, sensor_proc_b ^ stat_sensor_b}))
        else $error("sensor polarity changed during operation");
    dir_decode_a: assert property (live |->
        {rotate_clockwise, rotate_anticlockwise} == $past(dir_want, 3))
        else $error("direction decode wrong");
    speed_code_a: assert property (live |-> speed_code == $past(sel_now, 3))
        else $error("speed code wrong");
    freq_select_a: assert property (live |->
        out_freq_hz == freq_of($past(sel_now, 3), $past(pot_setpoint_freq, 3)))
        else $error("output frequency wrong");
    fault_lit_a: assert property (src_held_s ##0 live |-> fault_led_red)
        else $error("lamp dark while fault present");
    key_ack_a: assert property (quiet_s ##0 ($rose(key_off_reset) && live) |->
        ##3 !fault_led_red)
        else $error("key reset did not clear lamp");
endmodule

bind ssio_top ssio_props #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) ssio_props_u (
    .aclk(aclk), .aresetn(aresetn), .cmd(cmd), .sensor_chan_a(sensor_chan_a),
    .sensor_chan_b(sensor_chan_b), .fault_src(fault_src), .key_off_reset(key_off_reset),
    .pot_setpoint_freq(pot_setpoint_freq), .rotate_clockwise(rotate_clockwise),
    .rotate_anticlockwise(rotate_anticlockwise), .speed_code(speed_code),
    .out_freq_hz(out_freq_hz), .stat_sensor_a(stat_sensor_a), .stat_sensor_b(stat_sensor_b),
    .sensor_proc_a(sensor_proc_a), .sensor_proc_b(sensor_proc_b),
    .fault_led_red(fault_led_red));
